// ==== src/pcr_pkg.sv ====
// constants for the port capability register bank
package pcr_pkg;
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFF_CAP_HEADER  = 8'h40;
	localparam logic [7:0]  OFF_DEV_CAP     = 8'h44;
	// header fields
	localparam int          HDR_ID_LSB      = 0;
	localparam int          HDR_NXT_LSB     = 8;
	localparam int          HDR_VER_LSB     = 16;
	localparam int          HDR_TYPE_LSB    = 20;
	localparam int          HDR_SLOT_BIT    = 24;
	localparam int          HDR_IMN_LSB     = 25;
	localparam logic [7:0]  CAP_ID_VALUE    = 8'h10;
	localparam logic [7:0]  NXT_PTR_RESET   = 8'hC0;
	localparam logic [3:0]  CAP_VER_RESET   = 4'h2;
	localparam logic [3:0]  TYPE_UPSTREAM   = 4'h5;
	localparam logic [3:0]  TYPE_DOWNSTREAM = 4'h6;
	localparam logic        SLOT_RESET      = 1'h0;
	localparam logic [4:0]  IMN_VALUE       = 5'h00;
	// device capability fields
	localparam int          DC_MPS_LSB      = 0;
	localparam int          DC_PFS_LSB      = 3;
	localparam int          DC_EXTENDED_TAG_SUPPORTED_BIT     = 5;
	localparam int          DC_L0S_LSB      = 6;
	localparam int          DC_L1_LSB       = 9;
	localparam int          DC_ABP_BIT      = 12;
	localparam int          DC_AIP_BIT      = 13;
	localparam int          DC_PIP_BIT      = 14;
	localparam int          DC_RBER_BIT     = 15;
	localparam int          DC_PLV_LSB      = 18;
	localparam int          DC_PLS_LSB      = 26;
	localparam logic [2:0]  MPS_RESET       = 3'h4;
	localparam logic [1:0]  PFS_VALUE       = 2'h0;
	localparam logic        EXTENDED_TAG_SUPPORTED_RESET      = 1'h1;
	localparam logic [2:0]  LAT_VALUE       = 3'h0;
	localparam logic        PRESENT_VALUE   = 1'h0;
	localparam logic        RBER_VALUE      = 1'h1;
	localparam logic [7:0]  PLV_RESET       = 8'h00;
	localparam logic [1:0]  PLS_RESET       = 2'h0;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
endpackage : pcr_pkg

// ==== src/pcr_power_capture.sv ====
// captured slot power limit holder
`timescale 1ns/1ps
`default_nettype none
module pcr_power_capture (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_upstream,
	input  wire logic       i_load,
	input  wire logic [7:0] i_value,
	input  wire logic [1:0] i_scale,
	output logic      [7:0] o_value,
	output logic      [1:0] o_scale
);
	logic [7:0] value_reg;
	logic [1:0] scale_reg;

	// only the upstream port captures; downstream stays zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			value_reg <= pcr_pkg::PLV_RESET;
			scale_reg <= pcr_pkg::PLS_RESET;
		end else if (!i_upstream) begin
			value_reg <= pcr_pkg::PLV_RESET;
			scale_reg <= pcr_pkg::PLS_RESET;
		end else if (i_load) begin
			value_reg <= i_value;
			scale_reg <= i_scale;
		end
	end

	assign o_value = value_reg;
	assign o_scale = scale_reg;

	AST_CAPTURE_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_upstream && i_load) |=> (value_reg == $past(i_value)
		&& scale_reg == $past(i_scale)))
		else $error("power limit not captured");
	AST_DOWNSTREAM_ZERO: assert property (@(posedge i_clk)
		disable iff (!i_rst_n)
		(!i_upstream ##1 !i_upstream) |-> (value_reg == 8'h00
		&& scale_reg == 2'h0))
		else $error("downstream power limit nonzero");
endmodule : pcr_power_capture
`default_nettype wire

// ==== src/pcr_port_capability_regs.sv ====
// port capability register bank on an avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// - capability id always reads fixed code
// - next pointer resets C0, lockable write
// - version resets two, lockable write
// - port type fixed per port direction
// - slot bit resets zero, software's care
// - interrupt message number reads zero
// - max payload inits 2048 code, lockable
// - phantom functions hardwired zero
// - extended tag resets one, lockable
// - both exit latencies hardwired zero
// - button and indicator bits read zero
// - role based error bit reads one
// - upstream captures power value; downstream zero
// - upstream captures power scale; downstream zero
module pcr_port_capability_regs (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_UPSTREAM,
	input  wire logic        I_WRITE_LOCK_OPEN,
	input  wire logic        I_PWR_MSG_VALID,
	input  wire logic [7:0]  I_PWR_MSG_VALUE,
	input  wire logic [1:0]  I_PWR_MSG_SCALE,
	input  wire logic [7:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic      [31:0] O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST
);
	typedef enum logic [1:0] {ST_IDLE, ST_ACK} pcr_bus_st_t;

	pcr_bus_st_t st_reg;
	logic [7:0]  nxt_ptr_reg;
	logic [3:0]  cap_ver_reg;
	logic        slot_reg;
	logic [2:0]  mps_reg;
	logic        extended_tag_supported_reg;
	logic [31:0] rdata_reg;
	logic [7:0]  plv;
	logic [1:0]  pls;
	logic [31:0] hdr_word;
	logic [31:0] dcap_word;
	logic        wr_take;
	logic        wr_hdr;
	logic        wr_dcap;
	logic        wr_ok;

	////////////////////////////////////////////////////////////////////////
	// word assembly, reserved bits zero
	function automatic logic [31:0] pcr_hdr(input logic [7:0] nxt,
		input logic [3:0] capability_version, input logic up, input logic slot);
		logic [31:0] w;
		w = 32'h00000000;
		w[pcr_pkg::HDR_ID_LSB +: 8] = pcr_pkg::CAP_ID_VALUE;
		w[pcr_pkg::HDR_NXT_LSB +: 8] = nxt;
		w[pcr_pkg::HDR_VER_LSB +: 4] = capability_version;
		w[pcr_pkg::HDR_TYPE_LSB +: 4] = up ? pcr_pkg::TYPE_UPSTREAM
			: pcr_pkg::TYPE_DOWNSTREAM;
		w[pcr_pkg::HDR_SLOT_BIT] = slot;
		w[pcr_pkg::HDR_IMN_LSB +: 5] = pcr_pkg::IMN_VALUE;
		return w;
	endfunction : pcr_hdr

	function automatic logic [31:0] pcr_dcap(input logic [2:0] mps,
		input logic extended_tag_supported, input logic [7:0] v, input logic [1:0] s);
		logic [31:0] w;
		w = 32'h00000000;
		w[pcr_pkg::DC_MPS_LSB +: 3] = mps;
		w[pcr_pkg::DC_PFS_LSB +: 2] = pcr_pkg::PFS_VALUE;
		w[pcr_pkg::DC_EXTENDED_TAG_SUPPORTED_BIT] = extended_tag_supported;
		w[pcr_pkg::DC_L0S_LSB +: 3] = pcr_pkg::LAT_VALUE;
		w[pcr_pkg::DC_L1_LSB +: 3] = pcr_pkg::LAT_VALUE;
		w[pcr_pkg::DC_ABP_BIT] = pcr_pkg::PRESENT_VALUE;
		w[pcr_pkg::DC_AIP_BIT] = pcr_pkg::PRESENT_VALUE;
		w[pcr_pkg::DC_PIP_BIT] = pcr_pkg::PRESENT_VALUE;
		w[pcr_pkg::DC_RBER_BIT] = pcr_pkg::RBER_VALUE;
		w[pcr_pkg::DC_PLV_LSB +: 8] = v;
		w[pcr_pkg::DC_PLS_LSB +: 2] = s;
		return w;
	endfunction : pcr_dcap

	////////////////////////////////////////////////////////////////////////
	// power limit capture
	pcr_power_capture u_power (
		.i_clk      (I_CORE_CLK),
		.i_rst_n    (I_RST_N),
		.i_upstream (I_UPSTREAM),
		.i_load     (I_PWR_MSG_VALID),
		.i_value    (I_PWR_MSG_VALUE),
		.i_scale    (I_PWR_MSG_SCALE),
		.o_value    (plv),
		.o_scale    (pls)
	);

	assign hdr_word  = pcr_hdr(nxt_ptr_reg, cap_ver_reg, I_UPSTREAM, slot_reg);
	assign dcap_word = pcr_dcap(mps_reg, extended_tag_supported_reg, plv, pls);

	////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, answer in the second
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_reg <= ST_IDLE;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					if (I_AVS_READ || I_AVS_WRITE) begin
						st_reg <= ST_ACK;
					end
				end
				ST_ACK: st_reg <= ST_IDLE;
				default: st_reg <= ST_IDLE;
			endcase
		end
	end

	assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE)
		&& (st_reg != ST_ACK);
	assign wr_take = I_AVS_WRITE && (st_reg == ST_ACK);
	assign wr_ok   = wr_take && I_WRITE_LOCK_OPEN;
	assign wr_hdr  = wr_ok && (I_AVS_ADDRESS == pcr_pkg::OFF_CAP_HEADER);
	assign wr_dcap = wr_ok && (I_AVS_ADDRESS == pcr_pkg::OFF_DEV_CAP);

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata_reg <= 32'h00000000;
		end else if (I_AVS_READ && st_reg == ST_IDLE) begin
			case (I_AVS_ADDRESS)
				pcr_pkg::OFF_CAP_HEADER: rdata_reg <= hdr_word;
				pcr_pkg::OFF_DEV_CAP:    rdata_reg <= dcap_word;
				default:                 rdata_reg <= pcr_pkg::UNMAPPED_DATA;
			endcase
		end
	end

	assign O_AVS_READDATA = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// lockable header fields
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			nxt_ptr_reg <= pcr_pkg::NXT_PTR_RESET;
			cap_ver_reg <= pcr_pkg::CAP_VER_RESET;
			slot_reg    <= pcr_pkg::SLOT_RESET;
		end else if (wr_hdr) begin
			if (I_AVS_BYTEENABLE[1]) begin
				nxt_ptr_reg <= I_AVS_WRITEDATA[pcr_pkg::HDR_NXT_LSB +: 8];
			end
			if (I_AVS_BYTEENABLE[2]) begin
				cap_ver_reg <= I_AVS_WRITEDATA[pcr_pkg::HDR_VER_LSB +: 4];
			end
			if (I_AVS_BYTEENABLE[3]) begin
				slot_reg <= I_AVS_WRITEDATA[pcr_pkg::HDR_SLOT_BIT];
			end
		end
	end

	// lockable device capability fields
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mps_reg  <= pcr_pkg::MPS_RESET;
			extended_tag_supported_reg <= pcr_pkg::EXTENDED_TAG_SUPPORTED_RESET;
		end else if (wr_dcap && I_AVS_BYTEENABLE[0]) begin
			mps_reg  <= I_AVS_WRITEDATA[pcr_pkg::DC_MPS_LSB +: 3];
			extended_tag_supported_reg <= I_AVS_WRITEDATA[pcr_pkg::DC_EXTENDED_TAG_SUPPORTED_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_read_hdr;
		I_AVS_READ && st_reg == ST_IDLE
			&& I_AVS_ADDRESS == pcr_pkg::OFF_CAP_HEADER;
	endsequence

	sequence s_read_dcap;
		I_AVS_READ && st_reg == ST_IDLE
			&& I_AVS_ADDRESS == pcr_pkg::OFF_DEV_CAP;
	endsequence

	AST_CAP_ID: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		s_read_hdr |=> O_AVS_READDATA[7:0] == 8'h10)
		else $error("capability id wrong");
	AST_PORT_TYPE: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_read_hdr ##0 I_UPSTREAM ##1 I_UPSTREAM
		|-> O_AVS_READDATA[23:20] == 4'h5)
		else $error("upstream port type wrong");
	AST_IMN_RSVD: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_read_hdr |=> O_AVS_READDATA[31:25] == 7'h00)
		else $error("interrupt number or reserved nonzero");
	AST_DCAP_FIXED: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_read_dcap |=> (O_AVS_READDATA[4:3] == 2'h0
		&& O_AVS_READDATA[14:6] == 9'h000
		&& O_AVS_READDATA[15] == 1'b1))
		else $error("fixed device capability bits wrong");
	AST_DCAP_RSVD: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		s_read_dcap |=> (O_AVS_READDATA[17:16] == 2'h0
		&& O_AVS_READDATA[31:28] == 4'h0))
		else $error("reserved device capability bits nonzero");
	AST_LOCK_HOLDS: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(wr_take && !I_WRITE_LOCK_OPEN) |=> ($stable(nxt_ptr_reg)
		&& $stable(cap_ver_reg) && $stable(mps_reg)
		&& $stable(extended_tag_supported_reg)))
		else $error("locked field changed");
	AST_NXT_WRITE: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(wr_hdr && I_AVS_BYTEENABLE[1]) |=>
		nxt_ptr_reg == $past(I_AVS_WRITEDATA[15:8]))
		else $error("next pointer not written");
	AST_MPS_WRITE: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(wr_dcap && I_AVS_BYTEENABLE[0]) |=>
		(mps_reg == $past(I_AVS_WRITEDATA[2:0])
		&& extended_tag_supported_reg == $past(I_AVS_WRITEDATA[5])))
		else $error("payload or tag not written");
	AST_ANSWER_TIME: assert property (@(posedge I_CORE_CLK)
		disable iff (!I_RST_N)
		(st_reg == ST_IDLE && (I_AVS_READ || I_AVS_WRITE))
		|-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
		else $error("bus answer late");
	AST_VER_RESET: assert property (@(posedge I_CORE_CLK)
		$rose(I_RST_N) |-> cap_ver_reg == 4'h2)
		else $error("version reset wrong");
endmodule : pcr_port_capability_regs
`default_nettype wire

// ==== test/pcr_testbench.sv ====
// self-checking bench for the port capability register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk;
	logic        rst_n;
	logic        upstream;
	logic        lock_open;
	logic        pwr_valid;
	logic [7:0]  pwr_value;
	logic [1:0]  pwr_scale;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	int          miscompares = 0;
	int          n_compared  = 0;

	pcr_port_capability_regs DUT (
		.I_CORE_CLK        (clk),
		.I_RST_N           (rst_n),
		.I_UPSTREAM        (upstream),
		.I_WRITE_LOCK_OPEN (lock_open),
		.I_PWR_MSG_VALID   (pwr_valid),
		.I_PWR_MSG_VALUE   (pwr_value),
		.I_PWR_MSG_SCALE   (pwr_scale),
		.I_AVS_ADDRESS     (address),
		.I_AVS_READ        (read),
		.I_AVS_WRITE       (write),
		.I_AVS_WRITEDATA   (writedata),
		.I_AVS_BYTEENABLE  (byteenable),
		.O_AVS_READDATA    (readdata),
		.O_AVS_WAITREQUEST (waitrequest)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	task conclude;
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	// request held until waitrequest is sampled low at a rising edge
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		@(posedge clk);
		read       <= ~wr;
		write      <= wr;
		address    <= a;
		writedata  <= d;
		byteenable <= be;
		n = 0;
		@(posedge clk);
		while (waitrequest !== 1'b0 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n >= 20) miscompares++;
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, 4'hF, q);
		chk(q, exp);
	endtask : rd_chk

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		bus(1'b1, a, d, be, q);
	endtask : wr

	////////////////////////////////////////////////////////////////////
	task t_reset_values;
		rd_chk(8'h40, 32'h0052C010);
		rd_chk(8'h44, 32'h00008024);
	endtask : t_reset_values

	task t_unmapped;
		wr(8'h48, 32'hFFFFFFFF, 4'hF);
		rd_chk(8'h48, 32'h00000000);
		rd_chk(8'h40, 32'h0052C010);
	endtask : t_unmapped

	task t_lock;
		wr(8'h40, 32'h00000000, 4'hF);
		rd_chk(8'h40, 32'h0052C010);
		@(posedge clk);
		lock_open <= 1'b1;
		wr(8'h40, 32'h00000000, 4'h2);
		rd_chk(8'h40, 32'h00520010);
		wr(8'h40, 32'hFFFFFFFF, 4'hF);
		rd_chk(8'h40, 32'h015FFF10);
		wr(8'h44, 32'hFFFFFFFF, 4'hF);
		rd_chk(8'h44, 32'h00008027);
		wr(8'h44, 32'h00000000, 4'hF);
		rd_chk(8'h44, 32'h00008000);
		@(posedge clk);
		lock_open <= 1'b0;
		wr(8'h44, 32'hFFFFFFFF, 4'hF);
		rd_chk(8'h44, 32'h00008000);
	endtask : t_lock

	// every scale code captured with a distinct value on the upstream port
	task t_power;
		logic [31:0] exp;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			pwr_valid <= 1'b1;
			pwr_value <= 8'hAB ^ 8'(s * 8'h11);
			pwr_scale <= 2'(s);
			@(posedge clk);
			pwr_valid <= 1'b0;
			exp = 32'h00008000 | (32'(8'hAB ^ 8'(s * 8'h11)) << 18)
				| (32'(s) << 26);
			rd_chk(8'h44, exp);
		end
	endtask : t_power

	task t_downstream;
		@(posedge clk);
		upstream <= 1'b0;
		rd_chk(8'h44, 32'h00008000);
		rd_chk(8'h40, 32'h016FFF10);
		@(posedge clk);
		pwr_valid <= 1'b1;
		pwr_value <= 8'hFF;
		pwr_scale <= 2'h3;
		@(posedge clk);
		pwr_valid <= 1'b0;
		rd_chk(8'h44, 32'h00008000);
	endtask : t_downstream

	////////////////////////////////////////////////////////////////////
	initial begin
		rst_n      = 1'b0;
		upstream   = 1'b1;
		lock_open  = 1'b0;
		pwr_valid  = 1'b0;
		pwr_value  = 8'h00;
		pwr_scale  = 2'h0;
		address    = 8'h00;
		read       = 1'b0;
		write      = 1'b0;
		writedata  = 32'h00000000;
		byteenable = 4'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_values;
		t_unmapped;
		t_lock;
		t_power;
		t_downstream;
		conclude;
	end

	initial begin
		#20000;
		miscompares++;
		conclude;
	end
endmodule : testbench
`default_nettype wire
